// *** sysctl_defines.svh ***
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

`define OPC_W            10
`define NIB_W            4
`define RG_W             3

`define OPC_NOP          10'h000
`define OPC_SOFTWARE_SYSTEM_RESET_OP         10'h001
`define OPC_CLK_HOLD     10'h002
`define OPC_WAKE_TEST    10'h003
`define OPC_RAM_BACKUP   10'h008
`define OPC_BANK_LOW     10'h040
`define OPC_BANK_HIGH    10'h041
`define OPC_TBL_OFF      10'h058
`define OPC_TBL_ON       10'h059
`define OPC_PD_ARM       10'h05b
`define OPC_TAK0         10'h256
`define OPC_TAK1         10'h259
`define OPC_TAK2         10'h25a
`define OPC_TAK3         10'h25b
`define OPC_TK0A         10'h21b
`define OPC_TK1A         10'h214
`define OPC_TK2A         10'h215
`define OPC_TK3A         10'h22c
`define OPC_TAL1         10'h24a
`define OPC_TL1A         10'h20a
`define OPC_TL2A         10'h20b
`define OPC_TL3A         10'h20c
`define OPC_TC1A         10'h2a8
`define OPC_TC2A         10'h2a9
`define OPC_TC3A         10'h226
`define OPC_TAMR         10'h252
`define OPC_TMRA         10'h216
`define OPC_TRGA         10'h209
`define OPC_WDT_TEST     10'h2a0
`define OPC_WDT_ARM      10'h29c
`define OPC_VD_ON        10'h293
`define OPC_VD_TEST      10'h28a

`define NIB_RST          4'h0
`define RG_RST           3'h0

`define WB_ADDR_W        8
`define WB_OFS_STATUS    8'h00
`define WB_OFS_CTRL      8'h04
`define WB_OFS_KEYS      8'h08
`define WB_OFS_LCD       8'h0c
`define WB_OFS_CLOCK     8'h10
`define WB_ZERO          32'h0000_0000

`endif

// *** sysctl_pkg.sv ***
package sysctl_pkg;

  typedef struct packed {
    logic clock_hold;
    logic ram_backup;
  } power_state_t;

  typedef struct packed {
    logic [3:0] key3;
    logic [3:0] key2;
    logic [3:0] key1;
    logic [3:0] key0;
  } key_bank_t;

  typedef struct packed {
    logic [3:0] drive3;
    logic [3:0] drive2;
    logic [3:0] drive1;
    logic [3:0] lcd3;
    logic [3:0] lcd2;
    logic [3:0] lcd1;
  } lcd_bank_t;

endpackage : sysctl_pkg

// *** system_control_instr_exec.sv ***
// Notes on behaviour
// - key wakeup reads copy register into accumulator
// - key wakeup writes load accumulator into register
// - first lcd control register is readable
// - lcd and drive writes load from accumulator
// - clock mode register read and write
// - clock source register write only
// - no-operation only advances program counter
// - clock hold entry only after arming
// - ram backup entry only after arming
// - arming enables only the very next instruction
// - wake flag test skips when flag set
// - watchdog test clears flag, skips when set
// - watchdog test after stop-arm stops watchdog
// - table high bit off clears enable flag
// - table high bit on sets enable flag
// - vdrop detect kept active in power-down
// - vdrop test skips when flag set
// - low bank forces page bit six low
// - high bank forces page bit six high
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "sysctl_defines.svh"

module system_control_instr_exec
  import sysctl_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  instr_valid_i,
  input  wire logic [`OPC_W-1:0]     instr_word_i,
  input  wire logic [`NIB_W-1:0]     acc_i,
  input  wire logic                  wake_flag_i,
  input  wire logic                  wakeup_i,
  input  wire logic                  watchdog_overflow_i,
  input  wire logic                  vdrop_flag_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`WB_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       acc_load_o,
  output logic [`NIB_W-1:0]          acc_data_o,
  output logic                       skip_o,
  output logic                       pc_inc_o,
  output logic                       clock_hold_o,
  output logic                       ram_backup_o,
  output logic                       watchdog_stop_o,
  output logic                       watchdog_overflow_flag_o,
  output logic                       sys_reset_o,
  output logic                       table_high_bit_enable_o,
  output logic                       table_page_bit6_o,
  output logic                       vdrop_detect_en_o,
  output logic [`RG_W-1:0]           clock_source_o
);

  ////////////////////////////////////////////////////////////////////////////
  // internal reset: pin reset or software reset pulse

  logic                  rst_n;
  logic                  sys_reset_reg;
  logic                  skip_reg;
  logic                  exec;
  logic [`OPC_W-1:0]     op;
  logic                  pd_arm_reg;
  logic                  wdt_arm_reg;
  logic                  bank_high_reg;
  logic                  large_variant_reg;
  key_bank_t             key_reg;
  lcd_bank_t             lcd_reg;
  logic [`NIB_W-1:0]     clock_mode_reg;
  logic [`RG_W-1:0]      clock_source_reg;
  power_state_t          power_reg;
  logic                  wdt_flag_reg;
  logic                  acc_load_next;
  logic [`NIB_W-1:0]     acc_data_next;
  logic                  skip_next;

  // the software reset acts on the edge after the pulse, so the pulse is seen outside
  assign rst_n = reset_n_i & ~sys_reset_reg;
  assign op    = instr_word_i;
  // a skipped word still counts as taken but executes nothing
  assign exec  = instr_valid_i & ~skip_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      sys_reset_reg <= 1'b0;
    end else begin
      sys_reset_reg <= exec && op == `OPC_SOFTWARE_SYSTEM_RESET_OP;
    end
  end
  assign sys_reset_o = sys_reset_reg;

  ////////////////////////////////////////////////////////////////////////////
  // program counter and skip

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      pc_inc_o <= 1'b0;
    end else begin
      pc_inc_o <= instr_valid_i;
    end
  end

  always_comb begin
    skip_next = 1'b0;
    if (exec) begin
      case (op)
        `OPC_WAKE_TEST: skip_next = wake_flag_i;
        `OPC_WDT_TEST:  skip_next = wdt_flag_reg;
        `OPC_VD_TEST:   skip_next = vdrop_flag_i;
        default:        skip_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      skip_reg <= 1'b0;
    end else if (instr_valid_i) begin
      skip_reg <= skip_next;
    end
  end
  assign skip_o = skip_reg;

  ////////////////////////////////////////////////////////////////////////////
  // one-shot arming for power-down and watchdog stop

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      pd_arm_reg <= 1'b0;
    end else if (instr_valid_i) begin
      pd_arm_reg <= exec && op == `OPC_PD_ARM;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      wdt_arm_reg <= 1'b0;
    end else if (instr_valid_i) begin
      wdt_arm_reg <= exec && op == `OPC_WDT_ARM;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      watchdog_stop_o <= 1'b0;
    end else if (exec && op == `OPC_WDT_TEST && wdt_arm_reg) begin
      watchdog_stop_o <= 1'b1;
    end
  end

  // overflow set wins over the clearing test in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      wdt_flag_reg <= 1'b0;
    end else if (watchdog_overflow_i) begin
      wdt_flag_reg <= 1'b1;
    end else if (exec && op == `OPC_WDT_TEST) begin
      wdt_flag_reg <= 1'b0;
    end
  end
  assign watchdog_overflow_flag_o = wdt_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // power-down states, left by the wakeup event

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      power_reg <= '0;
    end else if (wakeup_i) begin
      power_reg <= '0;
    end else if (exec && pd_arm_reg && op == `OPC_CLK_HOLD) begin
      power_reg.clock_hold <= 1'b1;
    end else if (exec && pd_arm_reg && op == `OPC_RAM_BACKUP) begin
      power_reg.ram_backup <= 1'b1;
    end
  end
  assign clock_hold_o = power_reg.clock_hold;
  assign ram_backup_o = power_reg.ram_backup;

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      vdrop_detect_en_o <= 1'b0;
    end else if (exec && op == `OPC_VD_ON) begin
      vdrop_detect_en_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table reference flag and page bank

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      table_high_bit_enable_o <= 1'b0;
    end else if (exec && op == `OPC_TBL_OFF) begin
      table_high_bit_enable_o <= 1'b0;
    end else if (exec && op == `OPC_TBL_ON) begin
      table_high_bit_enable_o <= 1'b1;
    end
  end

  // on the small variant the bank selects are ignored; software must avoid them
  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      bank_high_reg <= 1'b0;
    end else if (exec && large_variant_reg && op == `OPC_BANK_LOW) begin
      bank_high_reg <= 1'b0;
    end else if (exec && large_variant_reg && op == `OPC_BANK_HIGH) begin
      bank_high_reg <= 1'b1;
    end
  end
  assign table_page_bit6_o = bank_high_reg;

  ////////////////////////////////////////////////////////////////////////////
  // peripheral control registers loaded from the accumulator

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      key_reg <= '0;
    end else if (exec) begin
      case (op)
        `OPC_TK0A: key_reg.key0 <= acc_i;
        `OPC_TK1A: key_reg.key1 <= acc_i;
        `OPC_TK2A: key_reg.key2 <= acc_i;
        `OPC_TK3A: key_reg.key3 <= acc_i;
        default:   key_reg <= key_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      lcd_reg <= '0;
    end else if (exec) begin
      case (op)
        `OPC_TL1A: lcd_reg.lcd1   <= acc_i;
        `OPC_TL2A: lcd_reg.lcd2   <= acc_i;
        `OPC_TL3A: lcd_reg.lcd3   <= acc_i;
        `OPC_TC1A: lcd_reg.drive1 <= acc_i;
        `OPC_TC2A: lcd_reg.drive2 <= acc_i;
        `OPC_TC3A: lcd_reg.drive3 <= acc_i;
        default:   lcd_reg <= lcd_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      clock_mode_reg <= `NIB_RST;
    end else if (exec && op == `OPC_TMRA) begin
      clock_mode_reg <= acc_i;
    end
  end

  // only the low three accumulator bits reach the source register
  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      clock_source_reg <= `RG_RST;
    end else if (exec && op == `OPC_TRGA) begin
      clock_source_reg <= acc_i[`RG_W-1:0];
    end
  end
  assign clock_source_o = clock_source_reg;

  ////////////////////////////////////////////////////////////////////////////
  // accumulator read paths; carry is never touched here

  always_comb begin
    acc_load_next = 1'b0;
    acc_data_next = `NIB_RST;
    if (exec) begin
      case (op)
        `OPC_TAK0: begin
          acc_load_next = 1'b1;
          acc_data_next = key_reg.key0;
        end
        `OPC_TAK1: begin
          acc_load_next = 1'b1;
          acc_data_next = key_reg.key1;
        end
        `OPC_TAK2: begin
          acc_load_next = 1'b1;
          acc_data_next = key_reg.key2;
        end
        `OPC_TAK3: begin
          acc_load_next = 1'b1;
          acc_data_next = key_reg.key3;
        end
        `OPC_TAL1: begin
          acc_load_next = 1'b1;
          acc_data_next = lcd_reg.lcd1;
        end
        `OPC_TAMR: begin
          acc_load_next = 1'b1;
          acc_data_next = clock_mode_reg;
        end
        default: begin
          acc_load_next = 1'b0;
          acc_data_next = `NIB_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      acc_load_o <= 1'b0;
      acc_data_o <= `NIB_RST;
    end else begin
      acc_load_o <= acc_load_next;
      acc_data_o <= acc_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after strobe, single-cycle pulse

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      large_variant_reg <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                 && wb_adr_i == `WB_OFS_CTRL) begin
      large_variant_reg <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      wb_dat_o <= `WB_ZERO;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      case (wb_adr_i)
        `WB_OFS_STATUS: wb_dat_o <= {24'h00_0000, skip_reg, wdt_arm_reg, pd_arm_reg,
                                     vdrop_detect_en_o, watchdog_stop_o, wdt_flag_reg,
                                     power_reg};
        `WB_OFS_CTRL:   wb_dat_o <= {29'h0000_0000, bank_high_reg,
                                     table_high_bit_enable_o, large_variant_reg};
        `WB_OFS_KEYS:   wb_dat_o <= {16'h0000, key_reg};
        `WB_OFS_LCD:    wb_dat_o <= {8'h00, lcd_reg};
        `WB_OFS_CLOCK:  wb_dat_o <= {25'h000_0000, clock_source_reg, clock_mode_reg};
        default:        wb_dat_o <= `WB_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_nop_no_load: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_NOP |=> pc_inc_o && !acc_load_o && !skip_reg)
    else $error("nop changed state");

  a_key_read_path: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_TAK2 |=> acc_load_o && acc_data_o == key_reg.key2)
    else $error("key read wrong");

  a_key_write_path: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_TK3A |=> key_reg.key3 == $past(acc_i))
    else $error("key write wrong");

  a_lcd_read_path: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_TAL1 |=> acc_load_o && acc_data_o == lcd_reg.lcd1)
    else $error("lcd read wrong");

  a_drive_write_path: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_TC3A |=> lcd_reg.drive3 == $past(acc_i))
    else $error("drive write wrong");

  a_mode_round_trip: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_TMRA ##1 exec && op == `OPC_TAMR
    |=> acc_data_o == $past(acc_i, 2))
    else $error("clock mode round trip wrong");

  a_source_write: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_TRGA |=> clock_source_o == $past(acc_i[`RG_W-1:0])
    && !acc_load_o)
    else $error("clock source write wrong");

  a_hold_needs_arm: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(clock_hold_o) |-> $past(pd_arm_reg) && $past(op) == `OPC_CLK_HOLD)
    else $error("clock hold without arming");

  a_backup_after_arm: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_PD_ARM ##1 exec && op == `OPC_RAM_BACKUP && !wakeup_i
    |=> ram_backup_o)
    else $error("ram backup not entered");

  a_arm_one_shot: assert property (@(posedge clk_i) disable iff (!rst_n)
    instr_valid_i && !(exec && op == `OPC_PD_ARM) |=> !pd_arm_reg)
    else $error("arming outlived next instruction");

  a_wake_skip: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_WAKE_TEST |=> skip_o == $past(wake_flag_i))
    else $error("wake test skip wrong");

  a_wdt_test_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_WDT_TEST && !watchdog_overflow_i
    |=> !watchdog_overflow_flag_o && skip_o == $past(wdt_flag_reg))
    else $error("watchdog test wrong");

  a_wdt_stop: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_WDT_ARM ##1 exec && op == `OPC_WDT_TEST
    |=> watchdog_stop_o)
    else $error("watchdog not stopped");

  a_table_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && (op == `OPC_TBL_ON || op == `OPC_TBL_OFF)
    |=> table_high_bit_enable_o == ($past(op) == `OPC_TBL_ON))
    else $error("table flag wrong");

  a_vdrop_enable: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_VD_ON |=> vdrop_detect_en_o [*2])
    else $error("vdrop detect not kept");

  a_vdrop_skip: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && op == `OPC_VD_TEST |=> skip_o == $past(vdrop_flag_i))
    else $error("vdrop test skip wrong");

  a_bank_select: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && large_variant_reg && (op == `OPC_BANK_LOW || op == `OPC_BANK_HIGH)
    |=> table_page_bit6_o == ($past(op) == `OPC_BANK_HIGH))
    else $error("bank select wrong");

  a_sw_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op == `OPC_SOFTWARE_SYSTEM_RESET_OP |=> sys_reset_o ##1 !power_reg.clock_hold
    && !table_high_bit_enable_o && !skip_reg)
    else $error("software reset incomplete");

  a_skip_suppress: assert property (@(posedge clk_i) disable iff (!rst_n)
    skip_reg && instr_valid_i |=> pc_inc_o && !acc_load_o && !skip_reg)
    else $error("skipped word executed");

  c_power_down: cover property (@(posedge clk_i) disable iff (!rst_n)
    $rose(clock_hold_o));
  c_skip_taken: cover property (@(posedge clk_i) disable iff (!rst_n)
    skip_reg && instr_valid_i);
  c_wdt_stop: cover property (@(posedge clk_i) disable iff (!rst_n)
    $rose(watchdog_stop_o));
  c_bank_high: cover property (@(posedge clk_i) disable iff (!rst_n)
    $rose(table_page_bit6_o));

endmodule : system_control_instr_exec

// *** tb.sv ***
`timescale 1ns/100ps
`include "sysctl_defines.svh"

module tb;
  logic                  clk_i, reset_n_i, instr_valid_i, wake_flag_i, wakeup_i;
  logic                  watchdog_overflow_i, vdrop_flag_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [`OPC_W-1:0]     instr_word_i;
  logic [`NIB_W-1:0]     acc_i, acc_data_o;
  logic [`WB_ADDR_W-1:0] wb_adr_i;
  logic [3:0]            wb_sel_i;
  logic [31:0]           wb_dat_i, wb_dat_o, rd;
  logic                  wb_ack_o, acc_load_o, skip_o, pc_inc_o, clock_hold_o, ram_backup_o;
  logic                  watchdog_stop_o, watchdog_overflow_flag_o, sys_reset_o;
  logic                  table_high_bit_enable_o, table_page_bit6_o, vdrop_detect_en_o;
  logic [`RG_W-1:0]      clock_source_o;
  int                    num_errors = 0;
  int                    samples_checked = 0;
  logic [`OPC_W-1:0]     key_wr [4] = '{`OPC_TK0A, `OPC_TK1A, `OPC_TK2A, `OPC_TK3A};
  logic [`OPC_W-1:0]     key_rd [4] = '{`OPC_TAK0, `OPC_TAK1, `OPC_TAK2, `OPC_TAK3};
  logic [`OPC_W-1:0]     lcd_wr [6] = '{`OPC_TL1A, `OPC_TL2A, `OPC_TL3A,
                                         `OPC_TC1A, `OPC_TC2A, `OPC_TC3A};

  system_control_instr_exec dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
    .instr_word_i(instr_word_i), .acc_i(acc_i), .wake_flag_i(wake_flag_i),
    .wakeup_i(wakeup_i), .watchdog_overflow_i(watchdog_overflow_i),
    .vdrop_flag_i(vdrop_flag_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_load_o(acc_load_o),
    .acc_data_o(acc_data_o), .skip_o(skip_o), .pc_inc_o(pc_inc_o),
    .clock_hold_o(clock_hold_o), .ram_backup_o(ram_backup_o),
    .watchdog_stop_o(watchdog_stop_o), .watchdog_overflow_flag_o(watchdog_overflow_flag_o),
    .sys_reset_o(sys_reset_o), .table_high_bit_enable_o(table_high_bit_enable_o),
    .table_page_bit6_o(table_page_bit6_o), .vdrop_detect_en_o(vdrop_detect_en_o),
    .clock_source_o(clock_source_o)
  );

  always #20 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one instruction, then an idle cycle; outputs are looked at in the answer cycle
  task automatic ex(input logic [`OPC_W-1:0] op, input logic [`NIB_W-1:0] a);
    @(posedge clk_i);
    instr_word_i  <= op;
    acc_i         <= a;
    instr_valid_i <= 1'h1;
    @(posedge clk_i);
    instr_valid_i <= 1'h0;
    #1;
    chk(pc_inc_o, 1'h1);
  endtask : ex

  // two instructions back to back with no idle cycle, then one idle cycle
  task automatic pair(input logic [`OPC_W-1:0] op1, input logic [`OPC_W-1:0] op2,
                      input logic [`NIB_W-1:0] a);
    @(posedge clk_i);
    instr_word_i  <= op1;
    acc_i         <= a;
    instr_valid_i <= 1'h1;
    @(posedge clk_i);
    instr_word_i  <= op2;
    @(posedge clk_i);
    instr_valid_i <= 1'h0;
    #1;
    chk(pc_inc_o, 1'h1);
  endtask : pair

  task automatic rda(input logic [`OPC_W-1:0] op, input logic [`NIB_W-1:0] exp);
    ex(op, 4'h0);
    chk({acc_load_o, acc_data_o}, {1'h1, exp});
  endtask : rda

  // ack is read before the edge's own updates land, so the sample is race free
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 16);
    if (wb_ack_o !== 1'h1) begin
      num_errors++;
      $display("MISMATCH t=%0t ack=%h exp=%h", $time, wb_ack_o, 1'h1);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb

  task automatic pulse(input logic wd);
    @(posedge clk_i);
    if (wd)
      watchdog_overflow_i <= 1'h1;
    else
      wakeup_i <= 1'h1;
    @(posedge clk_i);
    watchdog_overflow_i <= 1'h0;
    wakeup_i            <= 1'h0;
    #1;
  endtask : pulse

  task automatic summarize;
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  // whole run is about 150 cycles; the limit of 3000 cycles leaves wide margin
  initial begin
    #(40 * 3000);
    num_errors++;
    summarize();
  end

  initial begin
    clk_i = 1'h0;
    reset_n_i = 1'h0;
    instr_valid_i = 1'h0;
    instr_word_i = 10'h000;
    acc_i = 4'h0;
    wake_flag_i = 1'h0;
    wakeup_i = 1'h0;
    watchdog_overflow_i = 1'h0;
    vdrop_flag_i = 1'h0;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'h1;
    #1;
    chk({clock_hold_o, ram_backup_o, skip_o, watchdog_stop_o, vdrop_detect_en_o}, 5'h0);
    for (int i = 0; i < 4; i++) ex(key_wr[i], 4'h5 + 4'(i));
    for (int i = 0; i < 4; i++) rda(key_rd[i], 4'h5 + 4'(i));
    wb(1'h0, `WB_OFS_KEYS, 32'h0);
    chk(rd, 32'h0000_8765);
    for (int i = 0; i < 6; i++) ex(lcd_wr[i], 4'(i + 1));
    wb(1'h0, `WB_OFS_LCD, 32'h0);
    chk(rd, 32'h0065_4321);
    rda(`OPC_TAL1, 4'h1);
    ex(`OPC_TMRA, 4'ha);
    rda(`OPC_TAMR, 4'ha);
    ex(`OPC_TRGA, 4'hd);
    chk({acc_load_o, clock_source_o}, 4'h5);
    wb(1'h0, `WB_OFS_CLOCK, 32'h0);
    chk(rd, 32'h0000_005a);
    wb(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    pair(`OPC_TMRA, `OPC_TAMR, 4'h3);
    chk({acc_load_o, acc_data_o}, 5'h13);
    ex(`OPC_NOP, 4'hf);
    chk({acc_load_o, skip_o, sys_reset_o, clock_hold_o}, 4'h0);
    // power-down entry needs the arming word directly before it
    ex(`OPC_CLK_HOLD, 4'h0);
    chk(clock_hold_o, 1'h0);
    ex(`OPC_PD_ARM, 4'h0);
    ex(`OPC_NOP, 4'h0);
    ex(`OPC_CLK_HOLD, 4'h0);
    chk(clock_hold_o, 1'h0);
    ex(`OPC_PD_ARM, 4'h0);
    ex(`OPC_CLK_HOLD, 4'h0);
    chk({clock_hold_o, ram_backup_o}, 2'h2);
    pulse(1'h0);
    ex(`OPC_VD_ON, 4'h0);
    chk(vdrop_detect_en_o, 1'h1);
    ex(`OPC_PD_ARM, 4'h0);
    ex(`OPC_RAM_BACKUP, 4'h0);
    chk({clock_hold_o, ram_backup_o, vdrop_detect_en_o}, 3'h3);
    pulse(1'h0);
    pair(`OPC_PD_ARM, `OPC_RAM_BACKUP, 4'h0);
    chk({clock_hold_o, ram_backup_o}, 2'h1);
    pulse(1'h0);
    @(posedge clk_i);
    wake_flag_i <= 1'h1;
    ex(`OPC_WAKE_TEST, 4'h0);
    chk(skip_o, 1'h1);
    ex(`OPC_TK0A, 4'hc);
    chk(skip_o, 1'h0);
    rda(`OPC_TAK0, 4'h5);
    // a skipped arming word must not arm the next entry
    ex(`OPC_WAKE_TEST, 4'h0);
    ex(`OPC_PD_ARM, 4'h0);
    ex(`OPC_CLK_HOLD, 4'h0);
    chk(clock_hold_o, 1'h0);
    @(posedge clk_i);
    wake_flag_i <= 1'h0;
    ex(`OPC_WAKE_TEST, 4'h0);
    chk(skip_o, 1'h0);
    pulse(1'h1);
    chk(watchdog_overflow_flag_o, 1'h1);
    ex(`OPC_WDT_TEST, 4'h0);
    chk({skip_o, watchdog_overflow_flag_o, watchdog_stop_o}, 3'h4);
    ex(`OPC_NOP, 4'h0);
    ex(`OPC_WDT_TEST, 4'h0);
    chk({skip_o, watchdog_stop_o}, 2'h0);
    ex(`OPC_WDT_ARM, 4'h0);
    ex(`OPC_WDT_TEST, 4'h0);
    chk(watchdog_stop_o, 1'h1);
    ex(`OPC_TBL_ON, 4'h0);
    chk(table_high_bit_enable_o, 1'h1);
    ex(`OPC_TBL_OFF, 4'h0);
    chk(table_high_bit_enable_o, 1'h0);
    @(posedge clk_i);
    vdrop_flag_i <= 1'h1;
    ex(`OPC_VD_TEST, 4'h0);
    chk(skip_o, 1'h1);
    ex(`OPC_NOP, 4'h0);
    @(posedge clk_i);
    vdrop_flag_i <= 1'h0;
    ex(`OPC_VD_TEST, 4'h0);
    chk(skip_o, 1'h0);
    // bank selects count only on the larger variant
    ex(`OPC_BANK_HIGH, 4'h0);
    chk(table_page_bit6_o, 1'h0);
    wb(1'h1, `WB_OFS_CTRL, 32'h1);
    ex(`OPC_BANK_HIGH, 4'h0);
    chk(table_page_bit6_o, 1'h1);
    ex(`OPC_BANK_LOW, 4'h0);
    chk(table_page_bit6_o, 1'h0);
    ex(`OPC_BANK_HIGH, 4'h0);
    ex(`OPC_SOFTWARE_SYSTEM_RESET_OP, 4'h0);
    chk(sys_reset_o, 1'h1);
    @(posedge clk_i);
    #1;
    chk({watchdog_stop_o, vdrop_detect_en_o, table_page_bit6_o, clock_source_o}, 6'h0);
    wb(1'h0, `WB_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    rda(`OPC_TAK0, 4'h0);
    pair(`OPC_WDT_ARM, `OPC_WDT_TEST, 4'h0);
    chk(watchdog_stop_o, 1'h1);
    summarize();
  end
endmodule : tb
